// ---- logic/tre_pkg.sv ----
package tre_pkg;
  // status word layout
  localparam int SR_T_BIT = 15;
  localparam int SR_S_BIT = 13;
  localparam int SR_M_BIT = 12;
  localparam int SR_MASK_HI = 10;
  localparam int SR_MASK_LO = 8;
  localparam logic [15:0] SR_RST = 16'h2700;
  // frame longword 0 layout
  localparam int FMT_HI = 31;
  localparam int FMT_LO = 28;
  localparam logic [3:0] FMT_MIN = 4'h4;
  localparam logic [3:0] FMT_MAX = 4'h7;
  // vector numbers
  localparam logic [7:0] VEC_FORMAT = 8'h0E;
  localparam logic [7:0] VEC_TRACE = 8'h09;
  localparam logic [7:0] VEC_DEBUG = 8'h0C;
  localparam logic [7:0] VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
  // register port
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SR = 8'h08;
  localparam int CTRL_AUTOVEC_BIT = 0;
  localparam logic CTRL_AUTOVEC_RST = 1'b0;
  localparam int STAT_HALT_BIT = 0;
  localparam int STAT_STOP_BIT = 1;
  localparam int STAT_VEC_LO = 8;
  typedef enum logic [3:0] {
    TRE_IDLE = 4'b0000,
    TRE_EMIT = 4'b0001,
    TRE_INTERRUPT_ACKNOWLEDGE_CYCLE = 4'b0010,
    TRE_RTE_CHK = 4'b0011,
    TRE_RTE_SR = 4'b0100,
    TRE_RTE_FETCH = 4'b0101,
    TRE_RTE_SP = 4'b0110,
    TRE_RTE_JUMP = 4'b0111,
    TRE_STOPPED = 4'b1000,
    TRE_HALT = 4'b1001
  } tre_state_t;
endpackage

// ---- logic/tre_rte_check.sv ----
`timescale 1ns/1ps
module tre_rte_check
  import tre_pkg::*;
(
  // stacked frame
  input wire logic [31:0] frame0,
  input wire logic [31:0] sp_inc,
  // decoded
  output logic fmt_ok,
  output logic [31:0] new_sp,
  output logic [15:0] frame_sr
);
  logic [3:0] fmt;
  always_comb begin
    fmt = frame0[FMT_HI:FMT_LO];
    fmt_ok = (fmt >= FMT_MIN) && (fmt <= FMT_MAX);
    new_sp = sp_inc + {28'h000_0000, fmt};
    frame_sr = frame0[15:0];
  end
endmodule

// ---- logic/tre_irq_sel.sv ----
`timescale 1ns/1ps
module tre_irq_sel
  import tre_pkg::*;
(
  // request and mask
  input wire logic [2:0] irq_level,
  input wire logic [2:0] irq_mask,
  input wire logic autovec_en,
  // decision
  output logic irq_take,
  output logic use_interrupt_acknowledge_cycle,
  output logic [7:0] auto_vec
);
  always_comb begin
    irq_take = irq_level > irq_mask;
    use_interrupt_acknowledge_cycle = irq_take && !autovec_en;
    auto_vec = VEC_AUTO_BASE + {5'h00, irq_level};
  end
endmodule

// ---- logic/tre_exc_unit.sv ----
// Functional notes
// - trace exception after each instruction when enabled; here trap and return instructions take no trace
// - instruction before halt traces with halt address
// - halt loads status, traces with new status
// - halt setting trace bit raises trace too
// - no hardware stacking; handler checks stacked bit
// - breakpoint gives internal vector 12, no acknowledge
// - debug keeps master bit and mask unchanged
// - return checks format, bad format faults
// - format fault stacks return instruction address
// - valid return: status, fetch, stack adjust, jump
// - software trap always takes an exception; here a breakpoint in the same cycle wins and the trap is dropped
// - interrupts recognised, device vector fetched
// - autovector option replaces device vector
// - fault during exception halts until reset
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module tre_exc_unit
  import tre_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // instruction completion
  input wire logic instr_done,
  input wire logic [31:0] instr_pc,
  input wire logic [31:0] next_pc,
  input wire logic instr_is_stop,
  input wire logic [15:0] stop_imm,
  input wire logic instr_is_trap,
  input wire logic [3:0] trap_num,
  input wire logic instr_is_rte,
  input wire logic [31:0] rte_frame0,
  input wire logic [31:0] rte_sp_inc,
  input wire logic sr_wr,
  input wire logic [15:0] sr_wdata,
  input wire logic fault,
  // frame fetch
  output logic rte_fetch_req,
  input wire logic rte_fetch_ack,
  input wire logic [31:0] rte_fetch_data,
  // breakpoint and interrupt sources
  input wire logic bkpt_trig,
  input wire logic [2:0] irq_pin_level,
  // acknowledge cycle
  output logic interrupt_acknowledge_cycle_req,
  output logic [2:0] interrupt_acknowledge_cycle_level,
  input wire logic interrupt_acknowledge_cycle_ack,
  input wire logic interrupt_acknowledge_cycle_spurious,
  input wire logic [7:0] interrupt_acknowledge_cycle_vector,
  // exception entry and return
  output logic exc_valid,
  output logic [7:0] exc_vector,
  output logic [31:0] exc_pc,
  output logic [15:0] exc_sr,
  output logic [15:0] sr_out,
  output logic jump_valid,
  output logic [31:0] jump_pc,
  output logic sp_load,
  output logic [31:0] sp_value,
  output logic core_stopped,
  output logic core_halted
);
  tre_state_t state_r, state_nxt;
  logic [15:0] sr_r, sr_nxt;
  logic [7:0] vec_r, vec_nxt;
  logic [31:0] pc_r, pc_nxt;
  logic [15:0] ssr_r, ssr_nxt;
  logic keep_mask_r, keep_mask_nxt;
  logic [2:0] new_mask_r, new_mask_nxt;
  logic [31:0] frame0_r, frame0_nxt;
  logic [31:0] spinc_r, spinc_nxt;
  logic [31:0] jpc_r, jpc_nxt;
  logic [31:0] sp_r, sp_nxt;
  logic [2:0] lvl_r, lvl_nxt;
  logic autovec_r, autovec_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0] irq_s1_r, irq_s2_r;
  logic fmt_ok, irq_take, use_interrupt_acknowledge_cycle;
  logic [31:0] new_sp;
  logic [15:0] frame_sr;
  logic [7:0] auto_vec;

  function automatic logic [15:0] sr_enter(input logic [15:0] s);
    sr_enter = s;
    sr_enter[SR_S_BIT] = 1'b1;
    sr_enter[SR_T_BIT] = 1'b0;
  endfunction

  tre_rte_check u_rte (
    .frame0(frame0_r),
    .sp_inc(spinc_r),
    .fmt_ok(fmt_ok),
    .new_sp(new_sp),
    .frame_sr(frame_sr)
  );

  tre_irq_sel u_irq (
    .irq_level(irq_s2_r),
    .irq_mask(sr_r[SR_MASK_HI:SR_MASK_LO]),
    .autovec_en(autovec_r),
    .irq_take(irq_take),
    .use_interrupt_acknowledge_cycle(use_interrupt_acknowledge_cycle),
    .auto_vec(auto_vec)
  );

  always_comb begin
    state_nxt = state_r;
    sr_nxt = sr_wr ? sr_wdata : sr_r;
    vec_nxt = vec_r;
    pc_nxt = pc_r;
    ssr_nxt = ssr_r;
    keep_mask_nxt = keep_mask_r;
    new_mask_nxt = new_mask_r;
    frame0_nxt = frame0_r;
    spinc_nxt = spinc_r;
    jpc_nxt = jpc_r;
    sp_nxt = sp_r;
    lvl_nxt = lvl_r;
    autovec_nxt = autovec_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr && reg_addr == REG_CTRL) begin
      autovec_nxt = reg_wdata[CTRL_AUTOVEC_BIT];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: rdata_nxt[CTRL_AUTOVEC_BIT] = autovec_r;
        REG_STATUS: begin
          rdata_nxt[STAT_HALT_BIT] = state_r == TRE_HALT;
          rdata_nxt[STAT_STOP_BIT] = state_r == TRE_STOPPED;
          rdata_nxt[STAT_VEC_LO +: 8] = vec_r;
        end
        REG_SR: rdata_nxt[15:0] = sr_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    unique case (state_r)
      TRE_IDLE, TRE_STOPPED: begin
        keep_mask_nxt = 1'b1;
        if (bkpt_trig) begin
          vec_nxt = VEC_DEBUG;
          pc_nxt = state_r == TRE_STOPPED ? pc_r : next_pc;
          ssr_nxt = sr_r;
          state_nxt = TRE_EMIT;
        end else if (state_r == TRE_IDLE && instr_done && instr_is_rte) begin
          frame0_nxt = rte_frame0;
          spinc_nxt = rte_sp_inc;
          pc_nxt = instr_pc;
          state_nxt = TRE_RTE_CHK;
        end else if (state_r == TRE_IDLE && instr_done && instr_is_trap) begin
          vec_nxt = VEC_TRAP_BASE + {4'h0, trap_num};
          pc_nxt = next_pc;
          ssr_nxt = sr_r;
          state_nxt = TRE_EMIT;
        end else if (state_r == TRE_IDLE && instr_done && instr_is_stop) begin
          sr_nxt = stop_imm;
          pc_nxt = next_pc;
          if (stop_imm[SR_T_BIT] || sr_r[SR_T_BIT]) begin
            vec_nxt = VEC_TRACE;
            ssr_nxt = stop_imm;
            state_nxt = TRE_EMIT;
          end else begin
            state_nxt = TRE_STOPPED;
          end
        end else if (state_r == TRE_IDLE && instr_done && sr_r[SR_T_BIT]) begin
          vec_nxt = VEC_TRACE;
          pc_nxt = next_pc;
          ssr_nxt = sr_r;
          state_nxt = TRE_EMIT;
        end else if (irq_take) begin
          if (state_r == TRE_IDLE) begin
            pc_nxt = next_pc;
          end
          ssr_nxt = sr_r;
          lvl_nxt = irq_s2_r;
          keep_mask_nxt = 1'b0;
          new_mask_nxt = irq_s2_r;
          vec_nxt = auto_vec;
          state_nxt = use_interrupt_acknowledge_cycle ? TRE_INTERRUPT_ACKNOWLEDGE_CYCLE : TRE_EMIT;
        end
      end
      TRE_INTERRUPT_ACKNOWLEDGE_CYCLE: begin
        if (interrupt_acknowledge_cycle_ack) begin
          vec_nxt = interrupt_acknowledge_cycle_spurious ? VEC_SPURIOUS : interrupt_acknowledge_cycle_vector;
          state_nxt = TRE_EMIT;
        end
      end
      TRE_EMIT: begin
        sr_nxt = sr_enter(sr_r);
        if (!keep_mask_r) begin
          sr_nxt[SR_MASK_HI:SR_MASK_LO] = new_mask_r;
          sr_nxt[SR_M_BIT] = 1'b0;
        end
        state_nxt = TRE_IDLE;
      end
      TRE_RTE_CHK: begin
        if (fmt_ok) begin
          state_nxt = TRE_RTE_SR;
        end else begin
          vec_nxt = VEC_FORMAT;
          ssr_nxt = sr_r;
          keep_mask_nxt = 1'b1;
          state_nxt = TRE_EMIT;
        end
      end
      TRE_RTE_SR: begin
        sr_nxt = frame_sr;
        state_nxt = TRE_RTE_FETCH;
      end
      TRE_RTE_FETCH: begin
        if (rte_fetch_ack) begin
          jpc_nxt = rte_fetch_data;
          state_nxt = TRE_RTE_SP;
        end
      end
      TRE_RTE_SP: begin
        sp_nxt = new_sp;
        state_nxt = TRE_RTE_JUMP;
      end
      TRE_RTE_JUMP: state_nxt = TRE_IDLE;
      TRE_HALT: state_nxt = TRE_HALT;
      default: state_nxt = TRE_IDLE;
    endcase
    if (fault && state_r != TRE_IDLE && state_r != TRE_STOPPED) begin
      state_nxt = TRE_HALT;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= TRE_IDLE;
      sr_r <= SR_RST;
      vec_r <= 8'h00;
      pc_r <= 32'h0000_0000;
      ssr_r <= 16'h0000;
      keep_mask_r <= 1'b1;
      new_mask_r <= 3'h0;
      frame0_r <= 32'h0000_0000;
      spinc_r <= 32'h0000_0000;
      jpc_r <= 32'h0000_0000;
      sp_r <= 32'h0000_0000;
      lvl_r <= 3'h0;
      autovec_r <= CTRL_AUTOVEC_RST;
      rdata_r <= 32'h0000_0000;
      irq_s1_r <= 3'h0;
      irq_s2_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      sr_r <= sr_nxt;
      vec_r <= vec_nxt;
      pc_r <= pc_nxt;
      ssr_r <= ssr_nxt;
      keep_mask_r <= keep_mask_nxt;
      new_mask_r <= new_mask_nxt;
      frame0_r <= frame0_nxt;
      spinc_r <= spinc_nxt;
      jpc_r <= jpc_nxt;
      sp_r <= sp_nxt;
      lvl_r <= lvl_nxt;
      autovec_r <= autovec_nxt;
      rdata_r <= rdata_nxt;
      irq_s1_r <= irq_pin_level;
      irq_s2_r <= irq_s1_r;
    end
  end

  assign reg_rdata = rdata_r;
  assign exc_valid = state_r == TRE_EMIT;
  assign exc_vector = vec_r;
  assign exc_pc = pc_r;
  assign exc_sr = ssr_r;
  assign sr_out = sr_r;
  assign rte_fetch_req = state_r == TRE_RTE_FETCH;
  assign interrupt_acknowledge_cycle_req = state_r == TRE_INTERRUPT_ACKNOWLEDGE_CYCLE;
  assign interrupt_acknowledge_cycle_level = lvl_r;
  assign sp_load = state_r == TRE_RTE_JUMP;
  assign sp_value = sp_r;
  assign jump_valid = state_r == TRE_RTE_JUMP;
  assign jump_pc = jpc_r;
  assign core_stopped = state_r == TRE_STOPPED;
  assign core_halted = state_r == TRE_HALT;

  logic plain_done;
  assign plain_done = instr_done && !instr_is_stop && !instr_is_trap && !instr_is_rte;

  property p_trace;
    @(posedge clk) disable iff (sys_rst)
      state_r == TRE_IDLE && plain_done && sr_r[SR_T_BIT] && !bkpt_trig && !fault
      |=> exc_valid && exc_vector == VEC_TRACE && exc_pc == $past(next_pc);
  endproperty
  a_trace: assert property (p_trace) else $error("trace exception missing");

  property p_stop_trace;
    @(posedge clk) disable iff (sys_rst)
      state_r == TRE_IDLE && instr_done && instr_is_stop && stop_imm[SR_T_BIT] && !bkpt_trig
      |=> exc_valid && exc_sr == $past(stop_imm) && exc_pc == $past(next_pc);
  endproperty
  a_stop_trace: assert property (p_stop_trace) else $error("halt trace frame wrong");

  property p_debug_mask;
    @(posedge clk) disable iff (sys_rst)
      exc_valid && exc_vector == VEC_DEBUG && !interrupt_acknowledge_cycle_req && !sr_wr
      |=> sr_r[SR_M_BIT:SR_MASK_LO] == $past(sr_r[SR_M_BIT:SR_MASK_LO]);
  endproperty
  a_debug_mask: assert property (p_debug_mask) else $error("debug changed mask");

  property p_debug_noack;
    @(posedge clk) disable iff (sys_rst)
      (state_r == TRE_IDLE || state_r == TRE_STOPPED) && bkpt_trig && !fault
      |=> exc_valid && exc_vector == VEC_DEBUG && !interrupt_acknowledge_cycle_req;
  endproperty
  a_debug_noack: assert property (p_debug_noack) else $error("debug vector wrong");

  property p_fmt_err;
    @(posedge clk) disable iff (sys_rst)
      state_r == TRE_RTE_CHK && !fmt_ok && !fault
      |=> exc_valid && exc_vector == VEC_FORMAT && exc_pc == $past(pc_r);
  endproperty
  a_fmt_err: assert property (p_fmt_err) else $error("format error not raised");

  sequence s_rte_sr;
    state_r == TRE_RTE_CHK && fmt_ok && !fault ##1 state_r == TRE_RTE_SR && !fault;
  endsequence
  sequence s_rte_fetch;
    ##1 rte_fetch_req && sr_r == $past(frame_sr);
  endsequence
  property p_rte_seq;
    @(posedge clk) disable iff (sys_rst)
      s_rte_sr |-> s_rte_fetch;
  endproperty
  a_rte_seq: assert property (p_rte_seq) else $error("return order wrong");

  property p_rte_jump;
    @(posedge clk) disable iff (sys_rst)
      rte_fetch_req && rte_fetch_ack && !fault ##1 !fault
      |=> jump_valid && sp_load && jump_pc == $past(rte_fetch_data, 2);
  endproperty
  a_rte_jump: assert property (p_rte_jump) else $error("return jump wrong");

  property p_trap;
    @(posedge clk) disable iff (sys_rst)
      state_r == TRE_IDLE && instr_done && instr_is_trap && !bkpt_trig && !fault
      |=> exc_valid && exc_vector == VEC_TRAP_BASE + {4'h0, $past(trap_num)};
  endproperty
  a_trap: assert property (p_trap) else $error("trap not taken");

  property p_interrupt_acknowledge_cycle_vec;
    @(posedge clk) disable iff (sys_rst)
      interrupt_acknowledge_cycle_req && interrupt_acknowledge_cycle_ack && !interrupt_acknowledge_cycle_spurious && !fault
      |=> exc_valid && exc_vector == $past(interrupt_acknowledge_cycle_vector);
  endproperty
  a_interrupt_acknowledge_cycle_vec: assert property (p_interrupt_acknowledge_cycle_vec) else $error("device vector lost");

  property p_halt;
    @(posedge clk) disable iff (sys_rst)
      fault && (exc_valid || interrupt_acknowledge_cycle_req || rte_fetch_req) |=> core_halted [*8];
  endproperty
  a_halt: assert property (p_halt) else $error("fault on fault not halted");
endmodule

// ---- tb/tre_periph_model.sv ----
`timescale 1ns/1ps
module tre_periph_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // scenario control
  input wire logic [2:0] req_level,
  input wire logic [2:0] ack_delay,
  input wire logic [7:0] vec,
  input wire logic spur,
  // core side
  input wire logic interrupt_acknowledge_cycle_req,
  input wire logic [2:0] interrupt_acknowledge_cycle_level,
  output logic interrupt_acknowledge_cycle_ack,
  output logic interrupt_acknowledge_cycle_spurious,
  output logic [7:0] interrupt_acknowledge_cycle_vector,
  output logic [2:0] irq_pin_level
);
  logic served_r;
  logic [2:0] cnt_r;
  logic hit;
  // request held until its acknowledge has been given
  assign irq_pin_level = served_r ? 3'h0 : req_level;
  assign hit = interrupt_acknowledge_cycle_req && !interrupt_acknowledge_cycle_ack && (interrupt_acknowledge_cycle_level == req_level);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      served_r <= 1'b0;
      cnt_r <= 3'h0;
      interrupt_acknowledge_cycle_ack <= 1'b0;
      interrupt_acknowledge_cycle_spurious <= 1'b0;
      interrupt_acknowledge_cycle_vector <= 8'h00;
    end else begin
      served_r <= (req_level != 3'h0) && (served_r || interrupt_acknowledge_cycle_ack);
      if (hit && cnt_r == ack_delay) begin
        // answer the acknowledge cycle with the vector
        interrupt_acknowledge_cycle_ack <= 1'b1;
        interrupt_acknowledge_cycle_vector <= vec;
        interrupt_acknowledge_cycle_spurious <= spur;
        cnt_r <= 3'h0;
      end else begin
        interrupt_acknowledge_cycle_ack <= 1'b0;
        interrupt_acknowledge_cycle_spurious <= 1'b0;
        cnt_r <= hit ? cnt_r + 3'h1 : 3'h0;
        // vector lines are not held outside the answer
        interrupt_acknowledge_cycle_vector <= ~interrupt_acknowledge_cycle_vector;
      end
    end
  end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  import tre_pkg::*;
  logic clk, sys_rst, reg_wr, reg_rd, instr_done, instr_is_stop, instr_is_trap, instr_is_rte;
  logic sr_wr, fault, rte_fetch_req, rte_fetch_ack, bkpt_trig, interrupt_acknowledge_cycle_req, interrupt_acknowledge_cycle_ack, interrupt_acknowledge_cycle_spurious;
  logic exc_valid, jump_valid, sp_load, core_stopped, core_halted, spur;
  logic [7:0] reg_addr, interrupt_acknowledge_cycle_vector, exc_vector, vec;
  logic [31:0] reg_wdata, reg_rdata, instr_pc, next_pc, rte_frame0, rte_sp_inc, rte_fetch_data;
  logic [31:0] exc_pc, jump_pc, sp_value, fdata, jpc, jsp, jtgt;
  logic [15:0] stop_imm, sr_wdata, exc_sr, sr_out, esr, sr_req;
  logic [3:0] trap_num;
  logic [2:0] irq_pin_level, interrupt_acknowledge_cycle_level, req_level, ack_delay, lvl;
  logic [7:0] ev;
  logic [1:0] fcnt;
  int n_fail, comparisons, n_exc, n_jmp, n_interrupt_acknowledge_cycle, k0, j0;
  tre_exc_unit uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .instr_done(instr_done), .instr_pc(instr_pc), .next_pc(next_pc),
    .instr_is_stop(instr_is_stop), .stop_imm(stop_imm), .instr_is_trap(instr_is_trap),
    .trap_num(trap_num), .instr_is_rte(instr_is_rte), .rte_frame0(rte_frame0),
    .rte_sp_inc(rte_sp_inc), .sr_wr(sr_wr), .sr_wdata(sr_wdata), .fault(fault),
    .rte_fetch_req(rte_fetch_req), .rte_fetch_ack(rte_fetch_ack),
    .rte_fetch_data(rte_fetch_data), .bkpt_trig(bkpt_trig), .irq_pin_level(irq_pin_level),
    .interrupt_acknowledge_cycle_req(interrupt_acknowledge_cycle_req), .interrupt_acknowledge_cycle_level(interrupt_acknowledge_cycle_level), .interrupt_acknowledge_cycle_ack(interrupt_acknowledge_cycle_ack),
    .interrupt_acknowledge_cycle_spurious(interrupt_acknowledge_cycle_spurious), .interrupt_acknowledge_cycle_vector(interrupt_acknowledge_cycle_vector), .exc_valid(exc_valid),
    .exc_vector(exc_vector), .exc_pc(exc_pc), .exc_sr(exc_sr), .sr_out(sr_out),
    .jump_valid(jump_valid), .jump_pc(jump_pc), .sp_load(sp_load), .sp_value(sp_value),
    .core_stopped(core_stopped), .core_halted(core_halted));
  tre_periph_model peer (.clk(clk), .sys_rst(sys_rst), .req_level(req_level),
    .ack_delay(ack_delay), .vec(vec), .spur(spur), .interrupt_acknowledge_cycle_req(interrupt_acknowledge_cycle_req),
    .interrupt_acknowledge_cycle_level(interrupt_acknowledge_cycle_level), .interrupt_acknowledge_cycle_ack(interrupt_acknowledge_cycle_ack), .interrupt_acknowledge_cycle_spurious(interrupt_acknowledge_cycle_spurious),
    .interrupt_acknowledge_cycle_vector(interrupt_acknowledge_cycle_vector), .irq_pin_level(irq_pin_level));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // frame fetch answered two cycles late; data lines toggle otherwise
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fcnt <= 2'd0;
      rte_fetch_ack <= 1'b0;
      rte_fetch_data <= 32'h0000_0000;
    end else begin
      fcnt <= (rte_fetch_req === 1'b1 && !rte_fetch_ack) ? fcnt + 2'd1 : 2'd0;
      rte_fetch_ack <= rte_fetch_req === 1'b1 && !rte_fetch_ack && fcnt == 2'd1;
      rte_fetch_data <= (rte_fetch_req === 1'b1 && fcnt == 2'd1) ? fdata : ~rte_fetch_data;
    end
  end
  always @(posedge clk) begin
    if (rte_fetch_req === 1'b1 && fcnt == 2'd0 && !rte_fetch_ack) sr_req <= sr_out;
    if (exc_valid === 1'b1) begin
      n_exc++;
      ev <= exc_vector;
      esr <= exc_sr;
      jpc <= exc_pc;
    end
    if (jump_valid === 1'b1 && sp_load === 1'b1) begin
      n_jmp++;
      jsp <= sp_value;
      jtgt <= jump_pc;
    end
    if (interrupt_acknowledge_cycle_req === 1'b1) begin
      n_interrupt_acknowledge_cycle++;
      lvl <= interrupt_acknowledge_cycle_level;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk) reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) begin reg_rd <= 1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic set_sr(input logic [15:0] v);
    @(posedge clk) begin sr_wr <= 1; sr_wdata <= v; end
    @(posedge clk) sr_wr <= 0;
  endtask
  task automatic fire(input int k, input logic [31:0] a);
    @(posedge clk) begin
      instr_done <= 1; instr_is_stop <= k == 1; instr_is_trap <= k == 2;
      instr_is_rte <= k == 3; instr_pc <= a; next_pc <= a + 2;
    end
    @(posedge clk) begin instr_done <= 0; instr_is_stop <= 0; instr_is_trap <= 0; instr_is_rte <= 0; end
    wt(12);
  endtask
  task automatic exv(input logic [7:0] v, input logic [15:0] s);
    chk("exc count", k0 + 1, n_exc);
    chk("exc_vector", v, ev);
    chk("exc_sr", s, esr);
    k0 = n_exc;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    give_verdict;
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, instr_done, instr_is_stop, instr_is_trap, instr_is_rte} = 7'h01 << 6;
    {sr_wr, fault, bkpt_trig, spur, reg_addr, vec, trap_num, req_level, ack_delay} = 0;
    {reg_wdata, instr_pc, next_pc, rte_frame0, rte_sp_inc, fdata} = 0;
    {stop_imm, sr_wdata} = 0;
    wt(5);
    sys_rst <= 0;
    wt(3);
    chk("sr_out", 32'h2700, sr_out);
    rd(REG_SR, 32'h0000_2700);
    wr(REG_STATUS, 32'hFFFF_FFFF);
    rd(REG_STATUS, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0000);
    set_sr(16'hA700);
    fire(0, 32'h0000_0100);
    exv(VEC_TRACE, 16'hA700);
    chk("exc_pc", 32'h0000_0102, jpc);
    chk("sr_out", 32'h2700, sr_out);
    set_sr(16'hA700);
    stop_imm <= 16'h2000;
    fire(1, 32'h0000_0200);
    exv(VEC_TRACE, 16'h2000);
    chk("exc_pc", 32'h0000_0202, jpc);
    set_sr(16'h2700);
    stop_imm <= 16'hA300;
    fire(1, 32'h0000_0300);
    exv(VEC_TRACE, 16'hA300);
    chk("exc_pc", 32'h0000_0302, jpc);
    set_sr(16'h2700);
    stop_imm <= 16'h1500;
    fire(1, 32'h0000_0400);
    chk("sr_out", 32'h1500, sr_out);
    chk("core_stopped", 1, core_stopped);
    rd(REG_STATUS, 32'h0000_0902);
    @(posedge clk) bkpt_trig <= 1;
    @(posedge clk) bkpt_trig <= 0;
    wt(4);
    exv(VEC_DEBUG, 16'h1500);
    chk("sr_out", 32'h3500, sr_out);
    chk("interrupt_acknowledge_cycle cycles", 0, n_interrupt_acknowledge_cycle);
    // breakpoint while running rather than stopped
    @(posedge clk) bkpt_trig <= 1;
    @(posedge clk) bkpt_trig <= 0;
    wt(4);
    exv(VEC_DEBUG, 16'h3500);
    chk("exc_pc", 32'h0000_0402, jpc);
    chk("sr_out", 32'h3500, sr_out);
    chk("interrupt_acknowledge_cycle cycles", 0, n_interrupt_acknowledge_cycle);
    set_sr(16'h8700);
    trap_num <= 4'h3;
    fire(2, 32'h0000_0500);
    exv(VEC_TRAP_BASE + 8'h03, 16'h8700);
    for (int n = 0; n < 16; n++) begin
      set_sr(16'h0700);
      trap_num <= n[3:0];
      fire(2, 32'h0000_0500);
      exv(VEC_TRAP_BASE + n[7:0], 16'h0700);
      chk("sr_out", 32'h2700, sr_out);
    end
    for (int f = 0; f < 16; f++) begin
      set_sr(16'h2700);
      j0 = n_jmp;
      rte_frame0 <= {f[3:0], 12'h000, 16'h2300};
      rte_sp_inc <= 32'h0000_1000;
      fdata = 32'h0000_8000 + f * 16;
      fire(3, 32'h0000_0600);
      if (f >= 4 && f <= 7) begin
        chk("jump count", j0 + 1, n_jmp);
        chk("sr at fetch", 32'h2300, sr_req);
        chk("sp_value", 32'h0000_1000 + f, jsp);
        chk("jump_pc", 32'h0000_8000 + f * 16, jtgt);
        chk("exc count", k0, n_exc);
      end else begin
        exv(VEC_FORMAT, 16'h2700);
        chk("exc_pc", 32'h0000_0600, jpc);
        chk("jump count", j0, n_jmp);
      end
    end
    set_sr(16'h2000);
    wr(REG_CTRL, 32'h0000_0001);
    rd(REG_CTRL, 32'h0000_0001);
    req_level <= 3;
    wt(8);
    exv(VEC_AUTO_BASE + 8'h03, 16'h2000);
    chk("sr_out", 32'h2300, sr_out);
    chk("interrupt_acknowledge_cycle cycles", 0, n_interrupt_acknowledge_cycle);
    req_level <= 0;
    rd(REG_STATUS, 32'h0000_1B00);
    wr(REG_CTRL, 32'h0000_0000);
    set_sr(16'h2000);
    vec <= 8'h40;
    ack_delay <= 3;
    req_level <= 5;
    wt(16);
    exv(8'h40, 16'h2000);
    chk("interrupt_acknowledge_cycle_level", 5, lvl);
    chk("sr_out", 32'h2500, sr_out);
    req_level <= 0;
    set_sr(16'h2000);
    spur <= 1;
    req_level <= 6;
    wt(16);
    exv(VEC_SPURIOUS, 16'h2000);
    spur <= 0;
    req_level <= 0;
    set_sr(16'h2700);
    req_level <= 7;
    wt(16);
    chk("exc count", k0, n_exc);
    req_level <= 0;
    set_sr(16'h2000);
    ack_delay <= 7;
    req_level <= 4;
    for (int i = 0; i < 20 && interrupt_acknowledge_cycle_req !== 1'b1; i++) wt(1);
    @(posedge clk) fault <= 1;
    @(posedge clk) fault <= 0;
    wt(2);
    chk("core_halted", 1, core_halted);
    rd(REG_STATUS, 32'h0000_1C01);
    req_level <= 0;
    fire(2, 32'h0000_0700);
    chk("exc count", k0, n_exc);
    sys_rst <= 1;
    wt(2);
    sys_rst <= 0;
    wt(2);
    chk("core_halted", 0, core_halted);
    chk("sr_out", 32'h2700, sr_out);
    give_verdict;
  end
endmodule
